// File: rtl/ipc_inventory_param_control.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R1] four encodings: M2, M4, M8, FM0
// [R2] miller rate is link frequency over factor
// [R3] fm0 rate equals link frequency
// [R4] encoding resets to miller 4
// [R5] host uses M4/M8 in dense mode
// [R6] twelve rate combinations, three link frequencies
// [R7] region codes 0..18, 18 is custom
// [R8] slot exponent 0..15, zero means automatic
// [R9] nonzero q opens two-power-q slots
// [R10] auto q follows collision level
// [R11] slot exponent resets to automatic
// [R12] host session used in round queries
// [R13] target A, B or alternating dual
// [R14] rounds 0..10, zero means automatic
// [R15] auto rounds decided from collisions
// [R16] rounds setting resets to automatic
// [R17] results sent after every inventory round; the code stores each round's tags and sends them all only after the last round
// [R18] host pairs session 2/3 with M8
// [R19] link frequency resets to 256 kHz
// [R20] new settings apply at next round; the code applies them only at the next inv_start
module ipc_inventory_param_control #(
  parameter int RES_DEPTH = 16,
  parameter int RES_AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire ipc_pkg::ipc_cfg_t cfg_in,
  input wire logic inv_start,
  input wire logic qr_done,
  input wire logic [15:0] qr_coll,
  input wire logic [15:0] qr_tags,
  output logic cfg_err_r,
  output ipc_pkg::ipc_cfg_t act_cfg_r,
  output logic [3:0] q_work_r,
  output logic [15:0] slots_r,
  output logic target_b_r,
  output logic [8:0] rate_kbps_r,
  output logic [9:0] bw_khz_r,
  output logic custom_band_r,
  output logic qr_start_r,
  output logic busy_r,
  output logic inv_done_r,
  output ipc_pkg::ipc_result_t res_r
);

  // ==========================================================
  // helpers
  function automatic logic [8:0] lf_khz(input ipc_pkg::ipc_lf_t lf);
    case (lf)
      ipc_pkg::IPC_LF_160: lf_khz = ipc_pkg::IPC_LF_KHZ_160;
      ipc_pkg::IPC_LF_320: lf_khz = ipc_pkg::IPC_LF_KHZ_320;
      default: lf_khz = ipc_pkg::IPC_LF_KHZ_256;
    endcase
  endfunction : lf_khz

  function automatic logic [8:0] tag_rate(input ipc_pkg::ipc_cfg_t c);
    logic [8:0] f;
    f = lf_khz(c.lf);
    case (c.enc)
      // [R3] fm0 no division
      ipc_pkg::IPC_ENC_FM0: tag_rate = f;
      // [R2] divide by factor
      ipc_pkg::IPC_ENC_M2: tag_rate = f >> 1;
      ipc_pkg::IPC_ENC_M4: tag_rate = f >> 2;
      default: tag_rate = f >> 3;
    endcase
  endfunction : tag_rate

  // [R9] two power q slots
  function automatic logic [15:0] slot_count(input logic [3:0] q);
    slot_count = 16'h0001 << q;
  endfunction : slot_count

  // [R7] band width per region code
  function automatic logic [9:0] region_bw(input logic [4:0] r);
    case (r)
      5'h00, 5'h07, 5'h08, 5'h0A, 5'h0B, 5'h10: region_bw = ipc_pkg::IPC_BW_200;
      5'h02: region_bw = ipc_pkg::IPC_BW_250;
      5'h12: region_bw = ipc_pkg::IPC_BW_NONE;
      default: region_bw = ipc_pkg::IPC_BW_500;
    endcase
  endfunction : region_bw

  function automatic logic cfg_ok(input ipc_pkg::ipc_cfg_t c);
    cfg_ok = 1'b1;
    // [R6] only three link frequencies
    if (c.lf == 2'h3)
      cfg_ok = 1'b0;
    // [R7] region range check
    if (c.region > ipc_pkg::IPC_REGION_MAX)
      cfg_ok = 1'b0;
    // [R14] rounds range check
    if (c.rounds > ipc_pkg::IPC_ROUNDS_MAX)
      cfg_ok = 1'b0;
    // [R13] three target modes
    if (c.target == 2'h3)
      cfg_ok = 1'b0;
  endfunction : cfg_ok

  // ==========================================================
  // state
  ipc_pkg::ipc_state_t st_r;
  ipc_pkg::ipc_state_t st_nxt;
  logic [15:0] mem_rd_data;
  logic mem_wr_en;
  logic mem_rd_en;
  logic more_rounds;
  logic [3:0] next_cnt;

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    mem_wr_en = 1'b0;
    mem_rd_en = 1'b0;
    more_rounds = 1'b0;
    next_cnt = st_r.round_cnt + 4'h1;
    st_nxt.qr_start = 1'b0;
    st_nxt.inv_done = 1'b0;
    st_nxt.cfg_err = 1'b0;
    st_nxt.res = '0;

    // [R20] held until next inv_start
    if (cfg_wr)
    begin
      if (cfg_ok(cfg_in))
        st_nxt.pend = cfg_in;
      else
        st_nxt.cfg_err = 1'b1;
    end

    // [R1] enc field always one of four
    st_nxt.rate_kbps = tag_rate(st_r.act);
    st_nxt.slots = slot_count(st_r.q_work);
    st_nxt.bw_khz = region_bw(st_r.act.region);
    st_nxt.custom_band = (st_r.act.region == ipc_pkg::IPC_REGION_CUSTOM);

    case (st_r.fsm)
      ipc_pkg::IPC_ST_IDLE:
      begin
        if (inv_start)
        begin
          // [R20] apply at inventory start
          st_nxt.act = st_r.pend;
          // [R12] session latched for queries
          st_nxt.act.session = st_r.pend.session;
          // [R8] fixed or automatic q
          if (st_r.pend.q != ipc_pkg::IPC_Q_AUTO)
            st_nxt.q_work = st_r.pend.q;
          else if (st_r.act.q != ipc_pkg::IPC_Q_AUTO)
            st_nxt.q_work = ipc_pkg::IPC_Q_AUTO_INIT;
          // [R13] dual alternates per inventory
          case (st_r.pend.target)
            ipc_pkg::IPC_TGT_B: st_nxt.tgt_b = 1'b1;
            ipc_pkg::IPC_TGT_DUAL: st_nxt.tgt_b = (st_r.act.target == ipc_pkg::IPC_TGT_DUAL) ? !st_r.tgt_b : 1'b0;
            default: st_nxt.tgt_b = 1'b0;
          endcase
          st_nxt.round_cnt = 4'h0;
          st_nxt.busy = 1'b1;
          st_nxt.fsm = ipc_pkg::IPC_ST_QUERY;
        end
      end
      ipc_pkg::IPC_ST_QUERY:
      begin
        st_nxt.qr_start = 1'b1;
        st_nxt.fsm = ipc_pkg::IPC_ST_WAIT;
      end
      ipc_pkg::IPC_ST_WAIT:
      begin
        if (qr_done)
        begin
          mem_wr_en = 1'b1;
          st_nxt.round_cnt = next_cnt;
          // [R10] adapt working q
          if (st_r.act.q == ipc_pkg::IPC_Q_AUTO)
          begin
            if (qr_coll > (st_r.slots >> 1) && st_r.q_work != ipc_pkg::IPC_Q_MAX)
              st_nxt.q_work = st_r.q_work + 4'h1;
            else if (qr_coll < (st_r.slots >> 3) && st_r.q_work > 4'h1)
              st_nxt.q_work = st_r.q_work - 4'h1;
          end
          // [R15] another round if collisions
          if (st_r.act.rounds == ipc_pkg::IPC_ROUNDS_AUTO)
            more_rounds = (qr_coll != 16'h0000) && (next_cnt < ipc_pkg::IPC_ROUNDS_MAX);
          // [R14] fixed round count
          else
            more_rounds = next_cnt < st_r.act.rounds;
          if (more_rounds)
            st_nxt.fsm = ipc_pkg::IPC_ST_QUERY;
          else
          begin
            st_nxt.rd_idx = 4'h0;
            st_nxt.fsm = ipc_pkg::IPC_ST_REPORT;
          end
        end
      end
      ipc_pkg::IPC_ST_REPORT:
      begin
        // [R17] stream each round's tags
        st_nxt.rd_pend = 1'b0;
        if (st_r.rd_idx < st_r.round_cnt)
        begin
          mem_rd_en = 1'b1;
          st_nxt.rd_pend = 1'b1;
          st_nxt.rd_pend_idx = st_r.rd_idx;
          st_nxt.rd_idx = st_r.rd_idx + 4'h1;
        end
        else if (!st_r.rd_pend)
        begin
          st_nxt.busy = 1'b0;
          st_nxt.inv_done = 1'b1;
          st_nxt.fsm = ipc_pkg::IPC_ST_IDLE;
        end
        if (st_r.rd_pend)
        begin
          st_nxt.res.valid = 1'b1;
          st_nxt.res.round_idx = st_r.rd_pend_idx;
          st_nxt.res.tags = mem_rd_data;
          st_nxt.res.last = (st_r.rd_pend_idx + 4'h1 == st_r.round_cnt);
        end
      end
      default:
      begin
        st_nxt.fsm = ipc_pkg::IPC_ST_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.fsm <= ipc_pkg::IPC_ST_IDLE;
      // [R4] [R11] [R16] [R19] reset defaults
      st_r.pend <= ipc_pkg::IPC_CFG_RST;
      st_r.act <= ipc_pkg::IPC_CFG_RST;
      st_r.q_work <= ipc_pkg::IPC_Q_AUTO_INIT;
      st_r.rate_kbps <= 9'h040;
      st_r.slots <= 16'h0010;
      st_r.bw_khz <= ipc_pkg::IPC_BW_200;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // round result store
  ipc_round_mem #(
    .W(16),
    .D(RES_DEPTH),
    .AW(RES_AW)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_wr_en),
    .wr_addr(st_r.round_cnt),
    .wr_data(qr_tags),
    .rd_en(mem_rd_en),
    .rd_addr(st_r.rd_idx),
    .rd_data_r(mem_rd_data)
  );

  // ==========================================================
  // outputs, all from the state register
  assign cfg_err_r = st_r.cfg_err;
  assign act_cfg_r = st_r.act;
  assign q_work_r = st_r.q_work;
  assign slots_r = st_r.slots;
  assign target_b_r = st_r.tgt_b;
  assign rate_kbps_r = st_r.rate_kbps;
  assign bw_khz_r = st_r.bw_khz;
  assign custom_band_r = st_r.custom_band;
  assign qr_start_r = st_r.qr_start;
  assign busy_r = st_r.busy;
  assign inv_done_r = st_r.inv_done;
  assign res_r = st_r.res;

endmodule : ipc_inventory_param_control
`default_nettype wire

// File: rtl/ipc_pkg.sv
// ==========================================================
// inventory parameter package
package ipc_pkg;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    IPC_ENC_FM0 = 2'h0,
    IPC_ENC_M2 = 2'h1,
    IPC_ENC_M4 = 2'h2,
    IPC_ENC_M8 = 2'h3
  } ipc_enc_t;

  typedef enum logic [1:0] {
    IPC_LF_160 = 2'h0,
    IPC_LF_256 = 2'h1,
    IPC_LF_320 = 2'h2
  } ipc_lf_t;

  typedef enum logic [1:0] {
    IPC_TGT_A = 2'h0,
    IPC_TGT_B = 2'h1,
    IPC_TGT_DUAL = 2'h2
  } ipc_tgt_t;

  // gray order along idle, query, wait, report
  typedef enum logic [1:0] {
    IPC_ST_IDLE = 2'h0,
    IPC_ST_QUERY = 2'h1,
    IPC_ST_WAIT = 2'h3,
    IPC_ST_REPORT = 2'h2
  } ipc_fsm_t;

  // ==========================================================
  // limits and reset values
  localparam logic [4:0] IPC_REGION_MAX = 5'h12;
  localparam logic [4:0] IPC_REGION_CUSTOM = 5'h12;
  localparam logic [4:0] IPC_REGION_RST = 5'h00;
  localparam logic [3:0] IPC_Q_AUTO = 4'h0;
  localparam logic [3:0] IPC_Q_MAX = 4'hF;
  localparam logic [3:0] IPC_Q_AUTO_INIT = 4'h4;
  localparam logic [3:0] IPC_ROUNDS_MAX = 4'hA;
  localparam logic [3:0] IPC_ROUNDS_AUTO = 4'h0;
  localparam logic [1:0] IPC_SESSION_RST = 2'h0;
  localparam logic [8:0] IPC_LF_KHZ_160 = 9'h0A0;
  localparam logic [8:0] IPC_LF_KHZ_256 = 9'h100;
  localparam logic [8:0] IPC_LF_KHZ_320 = 9'h140;
  localparam logic [9:0] IPC_BW_200 = 10'h0C8;
  localparam logic [9:0] IPC_BW_250 = 10'h0FA;
  localparam logic [9:0] IPC_BW_500 = 10'h1F4;
  localparam logic [9:0] IPC_BW_NONE = 10'h000;

  // ==========================================================
  // carriers
  typedef struct packed {
    ipc_enc_t enc;
    ipc_lf_t lf;
    logic [4:0] region;
    logic [3:0] q;
    logic [1:0] session;
    ipc_tgt_t target;
    logic [3:0] rounds;
    logic dense_reader_mode;
  } ipc_cfg_t;

  localparam ipc_cfg_t IPC_CFG_RST = '{
    enc: IPC_ENC_M4,
    lf: IPC_LF_256,
    region: IPC_REGION_RST,
    q: IPC_Q_AUTO,
    session: IPC_SESSION_RST,
    target: IPC_TGT_A,
    rounds: IPC_ROUNDS_AUTO,
    dense_reader_mode: 1'b0
  };

  typedef struct packed {
    logic valid;
    logic last;
    logic [3:0] round_idx;
    logic [15:0] tags;
  } ipc_result_t;

  typedef struct packed {
    ipc_fsm_t fsm;
    ipc_cfg_t pend;
    ipc_cfg_t act;
    logic [3:0] q_work;
    logic tgt_b;
    logic [3:0] round_cnt;
    logic [3:0] rd_idx;
    logic rd_pend;
    logic [3:0] rd_pend_idx;
    logic qr_start;
    logic inv_done;
    logic busy;
    logic cfg_err;
    logic [8:0] rate_kbps;
    logic [15:0] slots;
    logic [9:0] bw_khz;
    logic custom_band;
    ipc_result_t res;
  } ipc_state_t;

endpackage : ipc_pkg

// File: rtl/ipc_round_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// per-query-round result store, registered read
module ipc_round_mem #(
  parameter int W = 16,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_r
);

  logic [W-1:0] mem [D];

  // array has no reset: contents are only read after being written this inventory
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_r <= '0;
    end
    else if (rd_en)
    begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule : ipc_round_mem
`default_nettype wire

// File: verif/ipc_param_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port-level checker
module ipc_param_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire ipc_pkg::ipc_cfg_t cfg_in,
  input wire logic inv_start,
  input wire logic cfg_err_r,
  input wire ipc_pkg::ipc_cfg_t act_cfg_r,
  input wire logic [3:0] q_work_r,
  input wire logic [15:0] slots_r,
  input wire logic target_b_r,
  input wire logic [8:0] rate_kbps_r,
  input wire logic custom_band_r,
  input wire logic qr_start_r,
  input wire logic busy_r,
  input wire logic inv_done_r,
  input wire ipc_pkg::ipc_result_t res_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic bad;
  logic [8:0] khz;
  assign bad = cfg_in.lf == 2'h3 || cfg_in.region > 5'h12 || cfg_in.rounds > 4'hA || cfg_in.target == 2'h3;
  // miller factor is a power of two, so its code doubles as a shift
  assign khz = act_cfg_r.lf == 2'h0 ? 9'h0A0 : (act_cfg_r.lf == 2'h1 ? 9'h100 : 9'h140);
  a_start_busy: assert property (inv_start && !busy_r |=> busy_r ##1 qr_start_r)
    else $error("start did not launch a query round");
  a_act_hold: assert property (!(inv_start && !busy_r) |=> $stable(act_cfg_r))
    else $error("active config changed without a start");
  a_rate_calc: assert property (rate_kbps_r == $past(khz >> act_cfg_r.enc))
    else $error("data rate wrong");
  a_custom_flag: assert property (custom_band_r == ($past(act_cfg_r.region) == 5'h12))
    else $error("custom band flag wrong");
  a_slots_pow: assert property (slots_r == 16'h0001 << $past(q_work_r))
    else $error("slot count wrong");
  a_err_flag: assert property (cfg_err_r == $past(cfg_wr && bad))
    else $error("config reject flag wrong");
  a_q_fixed: assert property (qr_start_r && act_cfg_r.q != 4'h0 |-> q_work_r == act_cfg_r.q)
    else $error("fixed q not applied");
  a_tgt_fixed: assert property (qr_start_r && act_cfg_r.target != 2'h2 |-> target_b_r == act_cfg_r.target[0])
    else $error("target wrong");
  a_done_last: assert property (res_r.valid && res_r.last |=> inv_done_r && !busy_r)
    else $error("done not after last word");
  a_idx_fixed: assert property (res_r.valid && res_r.last && act_cfg_r.rounds != 4'h0 |->
    res_r.round_idx == act_cfg_r.rounds - 4'h1)
    else $error("round count wrong");
  c_err: cover property (cfg_err_r);
  c_last: cover property (res_r.valid && res_r.last);
  c_tgt_b: cover property (qr_start_r && target_b_r);
endmodule : ipc_param_props
bind ipc_inventory_param_control ipc_param_props i_props (.clk, .rst_n, .cfg_wr, .cfg_in, .inv_start,
  .cfg_err_r, .act_cfg_r, .q_work_r, .slots_r, .target_b_r, .rate_kbps_r, .custom_band_r, .qr_start_r,
  .busy_r, .inv_done_r, .res_r);
`default_nettype wire

// File: verif/ipc_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// query engine stand-in, answers dly+1 cycles after each start
module ipc_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic qr_start,
  input wire logic [3:0] dly,
  input wire logic [15:0] coll,
  output logic qr_done,
  output logic [15:0] qr_coll,
  output logic [15:0] qr_tags
);
  logic run;
  logic [3:0] cnt;
  initial {run, cnt, qr_done, qr_coll, qr_tags} = '0;
  // data toggles outside the done pulse so stale values never pass as valid
  always @(negedge clk or negedge rst_n)
  begin
    qr_done <= 1'b0;
    qr_coll <= ~qr_coll;
    qr_tags <= ~qr_tags;
    if (!rst_n)
      run <= 1'b0;
    else if (qr_start)
    begin
      run <= 1'b1;
      cnt <= dly;
    end
    else if (run && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (run)
    begin
      run <= 1'b0;
      qr_done <= 1'b1;
      qr_coll <= coll;
      qr_tags <= 16'($urandom);
    end
  end
endmodule : ipc_engine_model
`default_nettype wire

// File: verif/ipc_inventory_param_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ipc_inventory_param_control_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic inv_start = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [15:0] coll = 16'h0000;
  ipc_pkg::ipc_cfg_t cfg_in = ipc_pkg::IPC_CFG_RST;
  ipc_pkg::ipc_cfg_t c;
  ipc_pkg::ipc_cfg_t nx;
  ipc_pkg::ipc_cfg_t act_cfg_r;
  ipc_pkg::ipc_result_t res_r;
  logic qr_done, cfg_err_r, target_b_r, custom_band_r, qr_start_r, busy_r, inv_done_r;
  logic [15:0] qr_coll, qr_tags, slots_r;
  logic [3:0] q_work_r;
  logic [8:0] rate_kbps_r;
  logic [9:0] bw_khz_r;
  logic [15:0] tq[$];
  int error_cnt = 0;
  int checked = 0;
  always #10 clk = ~clk;
  ipc_inventory_param_control i_dut (.clk, .rst_n, .cfg_wr, .cfg_in, .inv_start, .qr_done, .qr_coll, .qr_tags,
    .cfg_err_r, .act_cfg_r, .q_work_r, .slots_r, .target_b_r, .rate_kbps_r, .bw_khz_r, .custom_band_r,
    .qr_start_r, .busy_r, .inv_done_r, .res_r);
  ipc_engine_model i_eng (.clk, .rst_n, .qr_start(qr_start_r), .dly, .coll, .qr_done, .qr_coll, .qr_tags);
  always @(posedge clk)
    if (qr_done === 1'b1)
      tq.push_back(qr_tags);
  function automatic logic [9:0] bw_of(input logic [4:0] r);
    case (r)
      5'h00, 5'h07, 5'h08, 5'h0A, 5'h0B, 5'h10: bw_of = 10'h0C8;
      5'h02: bw_of = 10'h0FA;
      5'h12: bw_of = 10'h000;
      default: bw_of = 10'h1F4;
    endcase
  endfunction : bw_of
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wr(input ipc_pkg::ipc_cfg_t v, input logic err);
    @(negedge clk);
    cfg_in = v;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    chk("cfg_err", 32'(err), 32'(cfg_err_r));
  endtask : wr
  task automatic inv(input ipc_pkg::ipc_cfg_t e, input int r, input logic mid);
    int w;
    logic [8:0] f;
    w = 0;
    tq.delete();
    @(negedge clk);
    inv_start = 1'b1;
    @(negedge clk);
    inv_start = 1'b0;
    chk("busy", 1'b1, 32'(busy_r));
    chk("act", 32'(e), 32'(act_cfg_r));
    for (int k = 0; k < 3000 && busy_r === 1'b1; k++)
    begin
      cfg_in = nx;
      cfg_wr = mid && k == 2;
      if (res_r.valid === 1'b1)
      begin
        chk("idx", w, 32'(res_r.round_idx));
        chk("last", 32'(w == r - 1), 32'(res_r.last));
        chk("tags", 32'(tq.pop_front()), 32'(res_r.tags));
        w++;
      end
      @(negedge clk);
    end
    cfg_wr = 1'b0;
    chk("words", r, w);
    chk("done", 1'b1, 32'(inv_done_r));
    chk("act_hold", 32'(e), 32'(act_cfg_r));
    f = e.lf == ipc_pkg::IPC_LF_160 ? 9'h0A0 : (e.lf == ipc_pkg::IPC_LF_256 ? 9'h100 : 9'h140);
    chk("rate", 32'(f >> e.enc), 32'(rate_kbps_r));
    chk("bw", 32'(bw_of(e.region)), 32'(bw_khz_r));
    chk("custom", 32'(e.region == 5'h12), 32'(custom_band_r));
  endtask : inv
  initial
  begin
    void'($urandom(32'h0000_A0F4));
    nx = ipc_pkg::IPC_CFG_RST;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk("rst_act", 32'(ipc_pkg::IPC_CFG_RST), 32'(act_cfg_r));
    chk("rst_q", 32'(ipc_pkg::IPC_Q_AUTO_INIT), 32'(q_work_r));
    chk("rst_rate", 32'h0000_0040, 32'(rate_kbps_r));
    coll = 16'hFFFF;
    inv(ipc_pkg::IPC_CFG_RST, 10, 1'b0);
    chk("q_up", 32'h0000_000E, 32'(q_work_r));
    coll = 16'h0000;
    inv(ipc_pkg::IPC_CFG_RST, 1, 1'b0);
    chk("q_down", 32'h0000_000D, 32'(q_work_r));
    for (int i = 0; i < 12; i++)
    begin
      c = ipc_pkg::IPC_CFG_RST;
      c.lf = ipc_pkg::ipc_lf_t'(i / 4);
      c.enc = ipc_pkg::ipc_enc_t'(i % 4);
      c.q = 4'($urandom_range(15, 1));
      c.region = 5'($urandom_range(18, 0));
      c.session = 2'($urandom);
      c.target = ipc_pkg::ipc_tgt_t'($urandom_range(1, 0));
      c.rounds = 4'($urandom_range(3, 1));
      c.rounds = i == 11 ? 4'hA : c.rounds;
      c.q = i == 11 ? 4'hF : c.q;
      dly = 4'($urandom_range(7, 0));
      coll = 16'($urandom);
      wr(c, 1'b0);
      inv(c, c.rounds, 1'b0);
      chk("tgt", 32'(c.target == ipc_pkg::IPC_TGT_B), 32'(target_b_r));
      chk("slots", 32'(16'h0001 << c.q), 32'(slots_r));
    end
    for (int j = 0; j < 4; j++)
    begin
      nx = c;
      case (j)
        0: nx.region = 5'h13;
        1: nx.rounds = 4'hB;
        2: nx.lf = ipc_pkg::ipc_lf_t'(2'h3);
        default: nx.target = ipc_pkg::ipc_tgt_t'(2'h3);
      endcase
      wr(nx, 1'b1);
    end
    inv(c, c.rounds, 1'b0);
    c.target = ipc_pkg::IPC_TGT_DUAL;
    nx = c;
    nx.session = 2'h3;
    nx.enc = ipc_pkg::IPC_ENC_M8;
    nx.dense_reader_mode = 1'b1;
    wr(c, 1'b0);
    for (int j = 0; j < 3; j++)
    begin
      inv(j ? nx : c, c.rounds, j == 0);
      chk("dual", 32'(j % 2), 32'(target_b_r));
    end
    finish_test();
  end
  initial
  begin
    #1_000_000;
    error_cnt++;
    finish_test();
  end
endmodule : ipc_inventory_param_control_tb
`default_nettype wire
